//--- inc/biu_pkg.sv
// constants and carrier types for the serial bit i/o unit
package biu_pkg;

  // instruction word fields, bit 0 of the word is the msb
  localparam int OPC8_LSB   = 8;
  localparam int DISP_LSB   = 0;
  localparam int OPC6_LSB   = 10;
  localparam int CNT_LSB    = 6;
  localparam int MODE_LSB   = 4;
  localparam int SREG_LSB   = 0;

  // base workspace register: bits 3-14 of the word, bit 15 unused
  localparam int BASE_LSB   = 1;

  localparam logic [7:0] OPC_SET1 = 8'h1d;
  localparam logic [7:0] OPC_SET0 = 8'h1e;
  localparam logic [7:0] OPC_TEST = 8'h1f;
  localparam logic [5:0] OPC_MOUT = 6'h0c;
  localparam logic [5:0] OPC_MIN  = 6'h0d;

  // a zero count field moves sixteen bits
  localparam logic [4:0] FULL_COUNT = 5'h10;

  // address and output bit hold before the strobe or the input sample
  localparam int LINK_CLK_NS = 30;
  localparam int SETTLE_NS   = 60;
  localparam int SETTLE_CYC  =
    (SETTLE_NS + LINK_CLK_NS - 1) / LINK_CLK_NS;
  localparam logic [1:0] SETTLE_LAST = 2'(SETTLE_CYC - 1);

  // reset values
  localparam logic [11:0] ADDR_RST = 12'h000;
  localparam logic [15:0] WORD_RST = 16'h0000;

  typedef enum logic [2:0] {
    OP_SET1,
    OP_SET0,
    OP_TEST,
    OP_MOUT,
    OP_MIN
  } biu_op_e;

  typedef struct packed {
    biu_op_e     op;
    logic [11:0] addr;
    logic [4:0]  count;
    logic [15:0] data;
  } biu_cmd_s;

  typedef enum logic {
    C_IDLE,
    C_BUSY
  } biu_cstate_e;

  typedef enum logic [1:0] {
    L_IDLE,
    L_ADDR,
    L_STROBE
  } biu_lstate_e;

  typedef struct packed {
    biu_cstate_e st;
    logic        ready;
    logic        reqTgl;
    logic        ackSeen;
    biu_cmd_s    cmd;
    logic        rspValid;
    logic [15:0] rspData;
    logic        rspTestBit;
    logic        rspIllegal;
  } biu_cpu_s;

  typedef struct packed {
    biu_lstate_e st;
    logic        reqSeen;
    logic        ackTgl;
    logic [1:0]  settle;
    logic [11:0] addr;
    logic [4:0]  left;
    logic [15:0] shiftOut;
    logic [15:0] inWord;
    logic [3:0]  bitPos;
    logic        outBit;
    logic        strobe;
    logic        isInput;
    logic        isMulti;
  } biu_link_s;

endpackage

//--- logic/biu_bit_io_unit.sv
// processor-side bit i/o unit: decode, clock crossing and link sequencer
`timescale 1ns/1ps

// Function
// - three dedicated lines plus address bus
// - input line inbound, output line outbound
// - strobe pulse qualifies output line data
// - single-bit address is base plus displacement
// - base register bit 15 is ignored
// - set one/zero drives output line level
// - test bit samples addressed input level
// - count field sets bits; zero means 16
// - multibit start address is base only
// - multibit output sends source lsb first
// - address increments per bit until count
// - multibit input collects bits into word
module biu_bit_io_unit (
  input  wire logic        clk,            // cpu clock
  input  wire logic        rst_n,          // sync reset, active low
  input  wire logic        linkClk,        // bit i/o link clock
  input  wire logic        cmdValid,       // instruction offered
  input  wire logic [15:0] cmdInstr,       // instruction word
  input  wire logic [15:0] cmdBase,        // base workspace register
  input  wire logic [15:0] cmdData,        // source operand word
  output logic             cmdReady,       // unit can take a command
  output logic             rspValid,       // one-cycle completion
  output logic [15:0]      rspData,        // collected input word
  output logic             rspTestBit,     // sampled level of test
  output logic             rspIllegal,     // opcode not a bit i/o op
  output logic [11:0]      addrBus,        // bit address
  output logic             serialOutLine,  // bit data to peripheral
  output logic             bitStrobe,      // output data strobe
  input  wire logic        serialInLine    // bit data from peripheral
);

  biu_pkg::biu_cpu_s  cpu_reg;
  biu_pkg::biu_cpu_s  cpu_next;
  biu_pkg::biu_link_s link_reg;
  biu_pkg::biu_link_s link_next;

  logic reqSync;
  logic ackSync;
  logic inSync;
  logic linkRst_n;

  function automatic logic isSingle(input logic [15:0] instr);
    logic [7:0] opc;
    opc = instr[biu_pkg::OPC8_LSB +: 8];
    return (opc == biu_pkg::OPC_SET1) || (opc == biu_pkg::OPC_SET0) ||
           (opc == biu_pkg::OPC_TEST);
  endfunction

  function automatic logic isMulti(input logic [15:0] instr);
    logic [5:0] opc;
    opc = instr[biu_pkg::OPC6_LSB +: 6];
    return (opc == biu_pkg::OPC_MOUT) || (opc == biu_pkg::OPC_MIN);
  endfunction

  function automatic biu_pkg::biu_cmd_s decodeCmd(
    input logic [15:0] instr,
    input logic [15:0] base,
    input logic [15:0] data
  );
    biu_pkg::biu_cmd_s cmd;
    logic [11:0]       baseAddr;
    logic [7:0]        disp;
    logic [3:0]        cnt;
    logic [7:0]        opc8;
    logic [5:0]        opc6;
    baseAddr = base[biu_pkg::BASE_LSB +: 12];
    disp     = instr[biu_pkg::DISP_LSB +: 8];
    cnt      = instr[biu_pkg::CNT_LSB +: 4];
    opc8     = instr[biu_pkg::OPC8_LSB +: 8];
    opc6     = instr[biu_pkg::OPC6_LSB +: 6];
    cmd      = '0;
    cmd.data = data;
    if (isSingle(instr)) begin
      cmd.addr  = baseAddr + {{4{disp[7]}}, disp};
      cmd.count = 5'h01;
      if (opc8 == biu_pkg::OPC_SET1) begin
        cmd.op = biu_pkg::OP_SET1;
      end else if (opc8 == biu_pkg::OPC_SET0) begin
        cmd.op = biu_pkg::OP_SET0;
      end else begin
        cmd.op = biu_pkg::OP_TEST;
      end
    end else begin
      cmd.addr  = baseAddr;
      cmd.count = (cnt == 4'h0) ? biu_pkg::FULL_COUNT : {1'b0, cnt};
      if (opc6 == biu_pkg::OPC_MOUT) begin
        cmd.op = biu_pkg::OP_MOUT;
      end else begin
        cmd.op = biu_pkg::OP_MIN;
      end
    end
    return cmd;
  endfunction

  // crossings: request toggle into the link, done toggle back,
  // the input pin and the reset into the link domain
  biu_sync u_syncReq (
    .clk (linkClk),
    .d   (cpu_reg.reqTgl),
    .q   (reqSync)
  );

  biu_sync u_syncAck (
    .clk (clk),
    .d   (link_reg.ackTgl),
    .q   (ackSync)
  );

  biu_sync u_syncIn (
    .clk (linkClk),
    .d   (serialInLine),
    .q   (inSync)
  );

  biu_sync u_syncRst (
    .clk (linkClk),
    .d   (rst_n),
    .q   (linkRst_n)
  );

  // cpu domain: takes one instruction, waits for the link to finish
  always_comb begin
    cpu_next          = cpu_reg;
    cpu_next.rspValid = 1'b0;
    case (cpu_reg.st)
      biu_pkg::C_IDLE: begin
        if (cmdValid) begin
          if (isSingle(cmdInstr) || isMulti(cmdInstr)) begin
            cpu_next.cmd    = decodeCmd(cmdInstr, cmdBase, cmdData);
            // command word stays put until the done toggle returns
            cpu_next.reqTgl = ~cpu_reg.reqTgl;
            cpu_next.ready  = 1'b0;
            cpu_next.st     = biu_pkg::C_BUSY;
          end else begin
            cpu_next.rspValid   = 1'b1;
            cpu_next.rspIllegal = 1'b1;
          end
        end
      end
      biu_pkg::C_BUSY: begin
        if (ackSync != cpu_reg.ackSeen) begin
          cpu_next.ackSeen    = ackSync;
          cpu_next.rspValid   = 1'b1;
          cpu_next.rspIllegal = 1'b0;
          // link word is static once its done toggle has flipped
          cpu_next.rspData    = link_reg.inWord;
          // test result is the sampled level
          cpu_next.rspTestBit = link_reg.inWord[0];
          cpu_next.ready      = 1'b1;
          cpu_next.st         = biu_pkg::C_IDLE;
        end
      end
      default: begin
        cpu_next.st    = biu_pkg::C_IDLE;
        cpu_next.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cpu_reg            <= '0;
      cpu_reg.st         <= biu_pkg::C_IDLE;
      cpu_reg.ready      <= 1'b1;
      cpu_reg.rspData    <= biu_pkg::WORD_RST;
      cpu_reg.cmd.addr   <= biu_pkg::ADDR_RST;
    end else begin
      cpu_reg <= cpu_next;
    end
  end

  // link domain: one bit per address, settle then strobe or sample
  always_comb begin
    link_next        = link_reg;
    link_next.strobe = 1'b0;
    case (link_reg.st)
      biu_pkg::L_IDLE: begin
        if (reqSync != link_reg.reqSeen) begin
          link_next.reqSeen  = reqSync;
          link_next.addr     = cpu_reg.cmd.addr;
          link_next.left     = cpu_reg.cmd.count;
          link_next.shiftOut = cpu_reg.cmd.data;
          link_next.inWord   = biu_pkg::WORD_RST;
          link_next.bitPos   = 4'h0;
          link_next.settle   = 2'h0;
          link_next.isInput  = (cpu_reg.cmd.op == biu_pkg::OP_TEST) ||
                               (cpu_reg.cmd.op == biu_pkg::OP_MIN);
          link_next.isMulti  = (cpu_reg.cmd.op == biu_pkg::OP_MOUT);
          case (cpu_reg.cmd.op)
            // set one / set zero levels, first source bit for multibit output
            biu_pkg::OP_SET1: link_next.outBit = 1'b1;
            biu_pkg::OP_SET0: link_next.outBit = 1'b0;
            biu_pkg::OP_MOUT: link_next.outBit = cpu_reg.cmd.data[0];
            default:          link_next.outBit = 1'b0;
          endcase
          link_next.st = biu_pkg::L_ADDR;
        end
      end
      biu_pkg::L_ADDR: begin
        if (link_reg.settle == biu_pkg::SETTLE_LAST) begin
          // strobe only once address and data have settled
          link_next.strobe = ~link_reg.isInput;
          link_next.st     = biu_pkg::L_STROBE;
        end else begin
          link_next.settle = link_reg.settle + 2'h1;
        end
      end
      biu_pkg::L_STROBE: begin
        if (link_reg.isInput) begin
          // collect input bit at its position
          link_next.inWord[link_reg.bitPos] = inSync;
        end
        if (link_reg.left == 5'h01) begin
          link_next.ackTgl = ~link_reg.ackTgl;
          link_next.st     = biu_pkg::L_IDLE;
        end else begin
          // next address, next more significant bit
          link_next.left     = link_reg.left - 5'h01;
          link_next.addr     = link_reg.addr + 12'h001;
          link_next.bitPos   = link_reg.bitPos + 4'h1;
          link_next.shiftOut = {1'b0, link_reg.shiftOut[15:1]};
          link_next.outBit   = link_reg.isMulti & link_reg.shiftOut[1];
          link_next.settle   = 2'h0;
          link_next.st       = biu_pkg::L_ADDR;
        end
      end
      default: begin
        link_next.st = biu_pkg::L_IDLE;
      end
    endcase
  end

  always_ff @(posedge linkClk) begin
    if (!linkRst_n) begin
      link_reg          <= '0;
      link_reg.st       <= biu_pkg::L_IDLE;
      link_reg.addr     <= biu_pkg::ADDR_RST;
      link_reg.inWord   <= biu_pkg::WORD_RST;
      link_reg.shiftOut <= biu_pkg::WORD_RST;
    end else begin
      link_reg <= link_next;
    end
  end

  assign cmdReady      = cpu_reg.ready;
  assign rspValid      = cpu_reg.rspValid;
  assign rspData       = cpu_reg.rspData;
  assign rspTestBit    = cpu_reg.rspTestBit;
  assign rspIllegal    = cpu_reg.rspIllegal;
  assign addrBus       = link_reg.addr;
  assign serialOutLine = link_reg.outBit;
  assign bitStrobe     = link_reg.strobe;

endmodule

//--- logic/biu_sync.sv
// two flip-flop synchroniser for one level
`timescale 1ns/1ps

module biu_sync (
  input  wire logic clk,  // destination clock
  input  wire logic d,    // level from another domain
  output logic      q     // synchronised level
);

  logic meta_reg;
  logic q_reg;

  // no reset: the pair settles within two edges of its own clock
  always_ff @(posedge clk) begin
    meta_reg <= d;
    q_reg    <= meta_reg;
  end

  assign q = q_reg;

endmodule

//--- test/biu_bit_io_unit_asserts.sv
// concurrent checks on the bit i/o unit ports
`timescale 1ns/1ps
module biu_unit_asserts (
  input wire logic        clk,           // cpu clock
  input wire logic        rst_n,         // reset
  input wire logic        linkClk,       // link clock
  input wire logic        cmdValid,      // offer
  input wire logic [15:0] cmdInstr,      // instruction
  input wire logic        cmdReady,      // idle
  input wire logic        rspValid,      // done
  input wire logic [15:0] rspData,       // input word
  input wire logic        rspTestBit,    // test level
  input wire logic        rspIllegal,    // bad opcode
  input wire logic [11:0] addrBus,       // address
  input wire logic        serialOutLine, // out bit
  input wire logic        bitStrobe      // strobe
);
  logic        take;
  logic        legal;
  logic [2:0]  gap_reg;
  logic [11:0] lastAddr_reg;
  assign take  = cmdValid && cmdReady;
  assign legal = cmdInstr[15:8] inside {biu_pkg::OPC_SET1,
    biu_pkg::OPC_SET0, biu_pkg::OPC_TEST} || cmdInstr[15:10]
    inside {biu_pkg::OPC_MOUT, biu_pkg::OPC_MIN};
  always_ff @(posedge linkClk) begin
    if (!rst_n || bitStrobe) begin
      gap_reg <= rst_n ? 3'h0 : 3'h7;
      lastAddr_reg <= addrBus;
    end else if (gap_reg != 3'h7) begin
      gap_reg <= gap_reg + 3'h1;
    end
  end
  sequence s_held;
    $stable(addrBus) && $stable(serialOutLine);
  endsequence
  sequence s_quiet;
    !bitStrobe [*2];
  endsequence
  a_illegal_answer:
    assert property (@(posedge clk) disable iff (!rst_n)
      take && !legal |=> rspValid && rspIllegal)
    else $error("unknown opcode not answered next cycle");
  a_legal_answer:
    assert property (@(posedge clk) disable iff (!rst_n)
      take && legal |=> !rspValid ##[1:70] rspValid && !rspIllegal)
    else $error("bit operation not completed in time");
  a_busy_hold:
    assert property (@(posedge clk) disable iff (!rst_n)
      take && legal |=> !cmdReady [*2])
    else $error("ready while operation runs");
  a_ready_rise:
    assert property (@(posedge clk) disable iff (!rst_n)
      $rose(cmdReady) |-> rspValid)
    else $error("ready returned without response");
  a_rsp_single:
    assert property (@(posedge clk) disable iff (!rst_n)
      rspValid && !cmdValid |=> !rspValid)
    else $error("response pulse too long");
  a_test_copy:
    assert property (@(posedge clk) disable iff (!rst_n)
      rspValid |-> rspTestBit == rspData[0])
    else $error("test level differs from first input bit");
  a_strobe_gap:
    assert property (@(posedge linkClk) disable iff (!rst_n)
      bitStrobe |=> s_quiet)
    else $error("strobes closer than a bit slot");
  a_strobe_hold:
    assert property (@(posedge linkClk) disable iff (!rst_n)
      bitStrobe |-> s_held)
    else $error("address or data moved at strobe");
  a_addr_step:
    assert property (@(posedge linkClk) disable iff (!rst_n)
      bitStrobe && gap_reg <= 3'h4 |-> addrBus == lastAddr_reg + 12'h1)
    else $error("address did not step by one");
endmodule
bind biu_bit_io_unit biu_unit_asserts i_biu_unit_asserts (
  .clk(clk), .rst_n(rst_n), .linkClk(linkClk), .cmdValid(cmdValid),
  .cmdInstr(cmdInstr), .cmdReady(cmdReady), .rspValid(rspValid),
  .rspData(rspData), .rspTestBit(rspTestBit), .rspIllegal(rspIllegal),
  .addrBus(addrBus), .serialOutLine(serialOutLine),
  .bitStrobe(bitStrobe)
);

//--- test/biu_bit_model.sv
// far-side model: addressable output latches and input bits
`timescale 1ns/1ps
module biu_bit_model (
  input  wire logic [11:0] addrBus,       // bit address
  input  wire logic        serialOutLine, // bit from unit
  input  wire logic        bitStrobe,     // capture strobe
  output logic             serialInLine   // addressed input
);
  logic [4095:0] latchBits;
  int            strobeCnt;
  initial begin
    latchBits = '0;
    strobeCnt = 0;
  end
  always @(posedge bitStrobe) begin
    latchBits[addrBus] <= serialOutLine;
    strobeCnt <= strobeCnt + 1;
  end
  // addressed input level
  // a mixed pattern so that a wrong address shows as a wrong bit
  assign serialInLine = ^(addrBus & 12'h5a3);
endmodule

//--- test/test_biu_bit_io_unit.sv
// self-checking bench for the bit i/o unit and its far-side model
`timescale 1ns/1ps
module test_biu_bit_io_unit;
  logic        clk, rst_n, linkClk, cmdValid, cmdReady, rspValid;
  logic        rspTestBit, rspIllegal, serialOutLine, bitStrobe;
  logic        serialInLine;
  logic [15:0] cmdInstr, cmdBase, cmdData, rspData;
  logic [11:0] addrBus;
  int          fail_count, total_checks, cycles;

  biu_bit_io_unit i_biu_bit_io_unit (.clk(clk), .rst_n(rst_n),
    .linkClk(linkClk), .cmdValid(cmdValid), .cmdInstr(cmdInstr),
    .cmdBase(cmdBase), .cmdData(cmdData), .cmdReady(cmdReady),
    .rspValid(rspValid), .rspData(rspData), .rspTestBit(rspTestBit),
    .rspIllegal(rspIllegal), .addrBus(addrBus),
    .serialOutLine(serialOutLine), .bitStrobe(bitStrobe),
    .serialInLine(serialInLine));
  biu_bit_model i_biu_bit_model (.addrBus(addrBus),
    .serialOutLine(serialOutLine), .bitStrobe(bitStrobe),
    .serialInLine(serialInLine));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    linkClk = 1'b0;
    #7;
    forever #15 linkClk = ~linkClk;
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic pin(input logic [11:0] a);
    return ^(a & 12'h5a3);
  endfunction

  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // one command, taken at the next edge; waits for its response
  task run(input logic [15:0] ins, input logic [15:0] base,
           input logic [15:0] dat);
    int n;
    cmdInstr = ins;
    cmdBase  = base;
    cmdData  = dat;
    cmdValid = 1'b1;
    @(posedge clk);
    #1 cmdValid = 1'b0;
    n = 0;
    while (rspValid !== 1'b1 && n < 80) begin
      @(posedge clk);
      #1 n++;
    end
    chk(16'(n < 80), 16'h1);
  endtask

  task t_single;
    int s;
    s = i_biu_bit_model.strobeCnt;
    run({biu_pkg::OPC_SET1, 8'h04}, 16'h0121, 16'h0);
    chk(16'(i_biu_bit_model.latchBits[12'h094]), 16'h1);
    run({biu_pkg::OPC_SET1, 8'hff}, 16'h0120, 16'h0);
    chk(16'(i_biu_bit_model.latchBits[12'h08f]), 16'h1);
    run({biu_pkg::OPC_SET0, 8'hff}, 16'h0120, 16'h0);
    chk(16'(i_biu_bit_model.latchBits[12'h08f]), 16'h0);
    chk(16'(i_biu_bit_model.strobeCnt - s), 16'h3);
  endtask

  task t_test;
    int s;
    s = i_biu_bit_model.strobeCnt;
    run({biu_pkg::OPC_TEST, 8'h80}, 16'h0200, 16'h0);
    chk(16'(rspTestBit), 16'(pin(12'h080)));
    chk(16'(rspIllegal), 16'h0);
    run({biu_pkg::OPC_TEST, 8'hff}, 16'h0000, 16'h0);
    chk(16'(addrBus), 16'h0fff);
    chk(16'(rspTestBit), 16'(pin(12'hfff)));
    chk(16'(serialOutLine), 16'h0);
    chk(16'(i_biu_bit_model.strobeCnt - s), 16'h0);
  endtask

  task t_mout(input logic [3:0] c, input logic [15:0] base,
              input logic [15:0] dat);
    int s, n;
    logic [11:0] a;
    s = i_biu_bit_model.strobeCnt;
    n = (c == 4'h0) ? 16 : int'(c);
    run({biu_pkg::OPC_MOUT, c, 6'h00}, base, dat);
    a = base[12:1];
    for (int i = 0; i < n; i++) begin
      chk(16'(i_biu_bit_model.latchBits[a]), 16'(dat[i]));
      a++;
    end
    chk(16'(i_biu_bit_model.latchBits[a]), 16'h0);
    chk(16'(i_biu_bit_model.strobeCnt - s), 16'(n));
    chk(16'(addrBus), 16'(a - 12'h1));
  endtask

  task t_min(input logic [3:0] c, input logic [15:0] base);
    int n;
    logic [15:0] e;
    n = (c == 4'h0) ? 16 : int'(c);
    e = 16'h0;
    for (int i = 0; i < n; i++) e[i] = pin(base[12:1] + 12'(i));
    run({biu_pkg::OPC_MIN, c, 6'h2f}, base, 16'hffff);
    chk(rspData, e);
  endtask

  task t_illegal;
    run(16'h1000, 16'h0120, 16'h0);
    chk(16'(rspIllegal), 16'h1);
    chk(16'(cmdReady), 16'h1);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      finish_test;
    end
  end

  initial begin
    rst_n = 1'b0;
    cmdValid = 1'b0;
    cmdInstr = 16'h0;
    cmdBase = 16'h0;
    cmdData = 16'h0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    t_single;
    t_test;
    t_mout(4'h0, 16'h1ffc, 16'ha5c3);
    t_mout(4'h3, 16'h0400, 16'h000d);
    t_min(4'h5, 16'h0011);
    t_illegal;
    t_min(4'h0, 16'h1ffa);
    finish_test;
  end
endmodule
